// File: logic/smsbs_pkg.sv
/*
  shared constants of the byte shifter: register offsets, field positions,
  reset values and shift counts for both ends of the serial link.
  assumes 32-bit avalon-mm register access with byte addresses.
*/
`default_nettype none
package smsbs_pkg;
    // device end register map
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_PINS = 4'hC;
    // control field positions
    localparam int B_IRQEN = 7;
    localparam int B_EN = 6;
    localparam int B_LSB = 5;
    localparam int B_CSEL = 4;
    localparam int B_CPOL = 3;
    localparam int B_CPHA = 2;
    // status field positions
    localparam int B_DONE = 7;
    localparam int B_WRITE_COLLISION_FLAG = 6;
    localparam int B_DBL = 0;
    // pin control field positions
    localparam int P_MOSI = 0;
    localparam int P_MISO = 1;
    localparam int P_SCK = 2;
    localparam int P_SS = 3;
    localparam int P_SSV = 4;
    localparam int P_SSIN = 8;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [4:0] PINS_RST = 5'h10;
    // half sck period in clock cycles, indexed by {double, rate}
    localparam logic [6:0] HALF_TAB [0:7] = '{7'h02, 7'h08, 7'h20, 7'h40,
                                             7'h01, 7'h04, 7'h10, 7'h20};
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // far end register map
    localparam logic [3:0] F_OFS_CTRL = 4'h0;
    localparam logic [3:0] F_OFS_DATA = 4'h4;
    localparam logic [3:0] F_OFS_STAT = 4'h8;
    localparam int F_SSL = 0;
    localparam int F_CPOL = 1;
    localparam int F_CPHA = 2;
    localparam int F_LSB = 3;
    localparam logic [15:0] F_CTRL_RST = 16'h0201;
    localparam logic [7:0] F_HALF_MIN = 8'h02;
endpackage
`default_nettype wire

// File: logic/smsbs_link_if.sv
/*
  the four-wire serial link between the device end and the far end.
  resolves sck, mosi and select from the two drivers and their enables, miso from the device alone;
  undriven sck, mosi and miso read low, undriven select reads high.
*/
`timescale 1ns/1ps
`default_nettype none
interface smsbs_link_if;
    logic d_sck_o, d_sck_oe, d_mosi_o, d_mosi_oe;
    logic d_miso_o, d_miso_oe, d_ss_o, d_ss_oe;
    logic f_sck_o, f_sck_oe, f_mosi_o, f_mosi_oe, f_ss_o, f_ss_oe;
    logic sck, mosi, miso, ss_n;
    assign sck = d_sck_oe ? d_sck_o : (f_sck_oe & f_sck_o);
    assign mosi = d_mosi_oe ? d_mosi_o : (f_mosi_oe & f_mosi_o);
    assign miso = d_miso_oe & d_miso_o;
    assign ss_n = d_ss_oe ? d_ss_o : (f_ss_oe ? f_ss_o : 1'b1);
    modport dev(output d_sck_o, d_sck_oe, d_mosi_o, d_mosi_oe, d_miso_o,
                d_miso_oe, d_ss_o, d_ss_oe, input sck, mosi, miso, ss_n);
    modport far(output f_sck_o, f_sck_oe, f_mosi_o, f_mosi_oe, f_ss_o,
                f_ss_oe, input sck, miso);
endinterface
`default_nettype wire

// File: logic/smsbs_far.sv
/*
  far end: a plain serial controller that selects the device and shifts
  bytes with it, ordered by software over avalon-mm.
  assumes the link pins are resolved by the link interface.
*/
`timescale 1ns/1ps
`default_nettype none
module smsbs_far (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    smsbs_link_if.far LINK
);
    logic [15:0] ctrl_ff;
    logic [7:0] sh_ff, rx_ff, half;
    logic [3:0] ecnt_ff;
    logic [7:0] div_ff;
    logic run_ff, done_ff, sck_ff, out_ff, miso1_ff, miso2_ff, acc, tick, lead, samp, lsb;
    assign lsb = ctrl_ff[smsbs_pkg::F_LSB];
    // the device samples sck with its own clock, so never go faster than clock/4
    assign half = (ctrl_ff[15:8] < smsbs_pkg::F_HALF_MIN) ? smsbs_pkg::F_HALF_MIN : ctrl_ff[15:8];
    assign acc = (AVS_READ_I | AVS_WRITE_I) & ~AVS_WAITREQUEST_O;
    assign tick = run_ff & (div_ff == 8'h00);
    assign lead = sck_ff == ctrl_ff[smsbs_pkg::F_CPOL];
    assign samp = tick & (lead ^ ctrl_ff[smsbs_pkg::F_CPHA]);
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) AVS_WAITREQUEST_O <= 1'b1;
        else AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O);
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) AVS_READDATA_O <= 32'h0000_0000;
        else if (AVS_ADDRESS_I == smsbs_pkg::F_OFS_CTRL) AVS_READDATA_O <= {16'h0000, ctrl_ff};
        else if (AVS_ADDRESS_I == smsbs_pkg::F_OFS_DATA) AVS_READDATA_O <= {24'h00_0000, rx_ff};
        else if (AVS_ADDRESS_I == smsbs_pkg::F_OFS_STAT) AVS_READDATA_O <= {30'h0000_0000, done_ff, run_ff};
        else AVS_READDATA_O <= 32'h0000_0000;
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) ctrl_ff <= smsbs_pkg::F_CTRL_RST;
        else if (acc & AVS_WRITE_I & (AVS_ADDRESS_I == smsbs_pkg::F_OFS_CTRL)) ctrl_ff <= AVS_WRITEDATA_I[15:0];
    end
    always_ff @(posedge SYS_CLK_I) begin
        miso1_ff <= LINK.miso;
        miso2_ff <= miso1_ff;
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            run_ff <= 1'b0;
            ecnt_ff <= 4'h0;
            div_ff <= 8'h00;
            sh_ff <= 8'h00;
            out_ff <= 1'b0;
            done_ff <= 1'b0;
            rx_ff <= 8'h00;
        end else if (acc & AVS_WRITE_I & (AVS_ADDRESS_I == smsbs_pkg::F_OFS_DATA) & ~run_ff) begin
            run_ff <= 1'b1;
            ecnt_ff <= 4'h0;
            div_ff <= half - 8'h01;
            sh_ff <= AVS_WRITEDATA_I[7:0];
            out_ff <= lsb ? AVS_WRITEDATA_I[0] : AVS_WRITEDATA_I[7];
            done_ff <= 1'b0;
        end else if (tick) begin
            div_ff <= half - 8'h01;
            ecnt_ff <= ecnt_ff + 4'h1;
            if (samp) sh_ff <= lsb ? {miso2_ff, sh_ff[7:1]} : {sh_ff[6:0], miso2_ff};
            else out_ff <= lsb ? sh_ff[0] : sh_ff[7];
            if (ecnt_ff == smsbs_pkg::LAST_EDGE) begin
                run_ff <= 1'b0;
                done_ff <= 1'b1;
                rx_ff <= samp ? (lsb ? {miso2_ff, sh_ff[7:1]} : {sh_ff[6:0], miso2_ff}) : sh_ff;
            end
        end else if (run_ff) div_ff <= div_ff - 8'h01;
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I | ~run_ff) sck_ff <= ctrl_ff[smsbs_pkg::F_CPOL];
        else if (tick) sck_ff <= ~sck_ff;
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            LINK.f_sck_o <= 1'b0;
            LINK.f_sck_oe <= 1'b0;
            LINK.f_mosi_o <= 1'b0;
            LINK.f_mosi_oe <= 1'b0;
            LINK.f_ss_o <= 1'b1;
            LINK.f_ss_oe <= 1'b0;
        end else begin
            LINK.f_sck_o <= sck_ff;
            LINK.f_sck_oe <= 1'b1;
            LINK.f_mosi_o <= out_ff;
            LINK.f_mosi_oe <= 1'b1;
            LINK.f_ss_o <= ctrl_ff[smsbs_pkg::F_SSL];
            LINK.f_ss_oe <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: logic/smsbs_dev.sv
/*
  device end: byte shifter that works as controller or as selected target,
  with control, status, data and pin-direction registers on avalon-mm.
  assumes link inputs are asynchronous and sck is at most clock/4 as target.
*/
`timescale 1ns/1ps
`default_nettype none
module smsbs_dev (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic IRQ_ACK_I,
    output logic IRQ_O,
    smsbs_link_if.dev LINK
);
    logic [7:0] ctrl_ff, tx_ff, sh_ff, rx_ff, nxt_sh;
    logic [4:0] pins_ff;
    logic [3:0] sync1_ff, sync2_ff, ecnt_ff;
    logic [2:0] scnt_ff;
    logic [6:0] div_ff, half;
    logic dbl_ff, done_ff, write_collision_flag_ff, arm_done_ff, arm_write_collision_flag_ff;
    logic run_ff, sck_ff, out_ff, sck_prev_ff;
    logic en, mst, slv, lsb, cpol, cpha, sck_s, mosi_s, miso_s, ss_s, s_act;
    logic acc, rd_stat, acc_data, wr_data, load, collide, busy;
    logic tick, edge_ev, lead, samp, setup, in_bit, m_fin, s_fin, fin, ss_fault;

    assign en = ctrl_ff[smsbs_pkg::B_EN];
    assign mst = en & ctrl_ff[smsbs_pkg::B_CSEL];
    assign slv = en & ~ctrl_ff[smsbs_pkg::B_CSEL];
    assign lsb = ctrl_ff[smsbs_pkg::B_LSB];
    assign cpol = ctrl_ff[smsbs_pkg::B_CPOL];
    assign cpha = ctrl_ff[smsbs_pkg::B_CPHA];
    assign {ss_s, miso_s, mosi_s, sck_s} = sync2_ff;
    assign s_act = slv & ~ss_s;
    assign half = smsbs_pkg::HALF_TAB[{dbl_ff, ctrl_ff[1:0]}];

    // bus side
    assign acc = (AVS_READ_I | AVS_WRITE_I) & ~AVS_WAITREQUEST_O;
    assign rd_stat = acc & AVS_READ_I & (AVS_ADDRESS_I == smsbs_pkg::OFS_STAT);
    assign acc_data = acc & (AVS_ADDRESS_I == smsbs_pkg::OFS_DATA);
    assign wr_data = acc_data & AVS_WRITE_I;
    assign busy = run_ff | (s_act & (scnt_ff != 3'h0));
    assign load = wr_data & ~busy;
    assign collide = wr_data & busy;

    // shift timing, shared by both modes
    assign tick = run_ff & (div_ff == 7'h00);
    assign edge_ev = mst ? tick : (s_act & (sck_s != sck_prev_ff));
    assign lead = mst ? (sck_ff == cpol) : (sck_s != cpol);
    assign samp = edge_ev & (lead ^ cpha);
    assign setup = edge_ev & ~(lead ^ cpha);
    assign in_bit = mst ? miso_s : mosi_s;
    assign nxt_sh = lsb ? {in_bit, sh_ff[7:1]} : {sh_ff[6:0], in_bit};
    assign m_fin = mst & tick & (ecnt_ff == smsbs_pkg::LAST_EDGE);
    assign s_fin = s_act & samp & (scnt_ff == smsbs_pkg::LAST_BIT);
    assign fin = m_fin | s_fin;
    assign ss_fault = mst & ~pins_ff[smsbs_pkg::P_SS] & ~ss_s;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) AVS_WAITREQUEST_O <= 1'b1;
        else AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O);
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            AVS_READDATA_O <= 32'h0000_0000;
        end else if (AVS_ADDRESS_I == smsbs_pkg::OFS_CTRL) begin
            AVS_READDATA_O <= {24'h00_0000, ctrl_ff};
        end else if (AVS_ADDRESS_I == smsbs_pkg::OFS_STAT) begin
            AVS_READDATA_O <= {24'h00_0000, done_ff, write_collision_flag_ff, 5'h00, dbl_ff};
        end else if (AVS_ADDRESS_I == smsbs_pkg::OFS_DATA) begin
            AVS_READDATA_O <= {24'h00_0000, rx_ff};
        end else if (AVS_ADDRESS_I == smsbs_pkg::OFS_PINS) begin
            AVS_READDATA_O <= {23'h00_0000, ss_s, 3'h0, pins_ff};
        end else begin
            AVS_READDATA_O <= 32'h0000_0000;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            ctrl_ff <= smsbs_pkg::CTRL_RST;
        end else if (ss_fault) begin
            ctrl_ff[smsbs_pkg::B_CSEL] <= 1'b0;
        end else if (acc & AVS_WRITE_I & (AVS_ADDRESS_I == smsbs_pkg::OFS_CTRL)) begin
            ctrl_ff <= AVS_WRITEDATA_I[7:0];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            dbl_ff <= 1'b0;
            pins_ff <= smsbs_pkg::PINS_RST;
        end else if (acc & AVS_WRITE_I & (AVS_ADDRESS_I == smsbs_pkg::OFS_STAT)) begin
            dbl_ff <= AVS_WRITEDATA_I[smsbs_pkg::B_DBL];
        end else if (acc & AVS_WRITE_I & (AVS_ADDRESS_I == smsbs_pkg::OFS_PINS)) begin
            pins_ff <= AVS_WRITEDATA_I[4:0];
        end
    end

    // a set arriving with the clear wins, so no completion is lost
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) done_ff <= 1'b0;
        else if (fin | ss_fault) done_ff <= 1'b1;
        else if ((acc_data & arm_done_ff) | IRQ_ACK_I) done_ff <= 1'b0;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) write_collision_flag_ff <= 1'b0;
        else if (collide) write_collision_flag_ff <= 1'b1;
        else if (acc_data & arm_write_collision_flag_ff) write_collision_flag_ff <= 1'b0;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I | acc_data) begin
            arm_done_ff <= 1'b0;
            arm_write_collision_flag_ff <= 1'b0;
        end else if (rd_stat) begin
            arm_done_ff <= done_ff;
            arm_write_collision_flag_ff <= write_collision_flag_ff;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) IRQ_O <= 1'b0;
        else IRQ_O <= done_ff & ctrl_ff[smsbs_pkg::B_IRQEN] & ~IRQ_ACK_I;
    end

    // link pins come from another domain: two flops before any use
    always_ff @(posedge SYS_CLK_I) begin
        sync1_ff <= {LINK.ss_n, LINK.miso, LINK.mosi, LINK.sck};
        sync2_ff <= sync1_ff;
        sck_prev_ff <= sck_s;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) tx_ff <= 8'h00;
        else if (load) tx_ff <= AVS_WRITEDATA_I[7:0];
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            sh_ff <= 8'h00;
        end else if (load) begin
            sh_ff <= AVS_WRITEDATA_I[7:0];
        end else if (slv & ss_s) begin
            sh_ff <= tx_ff;
        end else if (samp) begin
            sh_ff <= nxt_sh;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) rx_ff <= 8'h00;
        else if (fin) rx_ff <= samp ? nxt_sh : sh_ff;
    end

    // first bit must be on the line before the first edge when phase is 0
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) out_ff <= 1'b0;
        else if (load) out_ff <= lsb ? AVS_WRITEDATA_I[0] : AVS_WRITEDATA_I[7];
        else if (slv & ss_s) out_ff <= lsb ? tx_ff[0] : tx_ff[7];
        else if (setup) out_ff <= lsb ? sh_ff[0] : sh_ff[7];
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I | load | ~s_act) scnt_ff <= 3'h0;
        else if (samp) scnt_ff <= scnt_ff + 3'h1;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            run_ff <= 1'b0;
            ecnt_ff <= 4'h0;
            div_ff <= 7'h00;
        end else if (load & mst) begin
            run_ff <= 1'b1;
            ecnt_ff <= 4'h0;
            div_ff <= half - 7'h01;
        end else if (m_fin | ss_fault | ~mst) begin
            run_ff <= 1'b0;
        end else if (tick) begin
            ecnt_ff <= ecnt_ff + 4'h1;
            div_ff <= half - 7'h01;
        end else if (run_ff) begin
            div_ff <= div_ff - 7'h01;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) sck_ff <= 1'b0;
        else if (~run_ff) sck_ff <= cpol;
        else if (tick) sck_ff <= ~sck_ff;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            LINK.d_sck_o <= 1'b0;
            LINK.d_sck_oe <= 1'b0;
            LINK.d_mosi_o <= 1'b0;
            LINK.d_mosi_oe <= 1'b0;
            LINK.d_miso_o <= 1'b0;
            LINK.d_miso_oe <= 1'b0;
            LINK.d_ss_o <= 1'b1;
            LINK.d_ss_oe <= 1'b0;
        end else if (mst) begin
            LINK.d_sck_o <= sck_ff;
            LINK.d_sck_oe <= pins_ff[smsbs_pkg::P_SCK];
            LINK.d_mosi_o <= out_ff;
            LINK.d_mosi_oe <= pins_ff[smsbs_pkg::P_MOSI];
            LINK.d_miso_o <= 1'b0;
            LINK.d_miso_oe <= 1'b0;
            LINK.d_ss_o <= pins_ff[smsbs_pkg::P_SSV];
            LINK.d_ss_oe <= pins_ff[smsbs_pkg::P_SS];
        end else if (slv) begin
            LINK.d_sck_oe <= 1'b0;
            LINK.d_mosi_oe <= 1'b0;
            LINK.d_ss_oe <= 1'b0;
            LINK.d_miso_o <= out_ff;
            LINK.d_miso_oe <= pins_ff[smsbs_pkg::P_MISO] & ~ss_s;
        end else begin
            LINK.d_sck_o <= cpol;
            LINK.d_sck_oe <= pins_ff[smsbs_pkg::P_SCK];
            LINK.d_mosi_o <= 1'b0;
            LINK.d_mosi_oe <= pins_ff[smsbs_pkg::P_MOSI];
            LINK.d_miso_o <= 1'b0;
            LINK.d_miso_oe <= pins_ff[smsbs_pkg::P_MISO];
            LINK.d_ss_o <= pins_ff[smsbs_pkg::P_SSV];
            LINK.d_ss_oe <= pins_ff[smsbs_pkg::P_SS];
        end
    end
endmodule
`default_nettype wire

// File: sim/smsbs_asserts.sv
/*
  concurrent checks on the serial link between the two ends.
  assumes the bench instantiates it beside the link interface.
*/
`timescale 1ns/1ps
`default_nettype none
module smsbs_asserts (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic d_sck_o,
    input wire logic d_sck_oe,
    input wire logic d_mosi_oe,
    input wire logic d_miso_oe,
    input wire logic d_ss_o,
    input wire logic d_ss_oe,
    input wire logic f_sck_o,
    input wire logic f_sck_oe,
    input wire logic ss_n
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RST_I);
    reset_quiet_a: assert property ($fell(RST_I) |-> !d_sck_oe && !d_mosi_oe && !d_miso_oe && !d_ss_oe && d_ss_o)
        else $error("device pins active after reset");
    ss_untouched_a: assert property (d_sck_oe && $changed(d_sck_o) |-> $stable(d_ss_o) && $stable(d_ss_oe))
        else $error("select moved while shifting");
    miso_idle_a: assert property (ss_n [*5] |-> !d_miso_oe)
        else $error("miso driven while deselected");
    miso_release_a: assert property ($rose(ss_n) |-> ##[0:4] !d_miso_oe)
        else $error("miso not released on deselect");
    pin_dirs_a: assert property (d_miso_oe |-> !d_sck_oe && !d_mosi_oe && !d_ss_oe)
        else $error("miso driven together with controller pins");
    target_mosi_a: assert property ((!ss_n && !d_ss_oe) [*6] |-> !d_mosi_oe)
        else $error("mosi driven while selected");
    target_sck_a: assert property (!ss_n && !d_ss_oe ##1 !ss_n && !d_ss_oe ##5 !ss_n && !d_ss_oe |-> !d_sck_oe)
        else $error("sck driven while selected");
    far_half_a: assert property (f_sck_oe && $changed(f_sck_o) |=> $stable(f_sck_o))
        else $error("far clock faster than clock over four");
endmodule
`default_nettype wire

// File: sim/smsbs_tb.sv
/*
  bench joining the device end and the far end over one link.
  assumes both ends answer avalon-mm with a registered waitrequest.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module smsbs_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ack = 1'b0;
    logic irq, cp, ch, ls;
    logic [3:0] adr [2] = '{default: '0};
    logic rd [2] = '{default: '0};
    logic wr [2] = '{default: '0};
    logic chk [2] = '{default: '0};
    logic wq [2];
    logic [31:0] wd [2] = '{default: '0};
    logic [31:0] rdat [2];
    logic [31:0] q0 [$];
    logic [31:0] q1 [$];
    logic [31:0] x, junk;
    logic [15:0] fc;
    logic [7:0] wm, a, b, rv;
    int n_errors = 0;
    int n_tests = 0;
    int edges = 0;
    int seed = 32'heac5_b7d7;
    time t0, t1;
    smsbs_link_if link ();
    smsbs_dev u_smsbs_dev (.SYS_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr[0]), .AVS_READ_I(rd[0]),
        .AVS_WRITE_I(wr[0]), .AVS_WRITEDATA_I(wd[0]), .AVS_READDATA_O(rdat[0]), .AVS_WAITREQUEST_O(wq[0]),
        .IRQ_ACK_I(ack), .IRQ_O(irq), .LINK(link));
    smsbs_far u_smsbs_far (.SYS_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr[1]), .AVS_READ_I(rd[1]),
        .AVS_WRITE_I(wr[1]), .AVS_WRITEDATA_I(wd[1]), .AVS_READDATA_O(rdat[1]), .AVS_WAITREQUEST_O(wq[1]),
        .LINK(link));
    smsbs_asserts u_smsbs_asserts (.SYS_CLK_I(clk), .RST_I(rst), .d_sck_o(link.d_sck_o),
        .d_sck_oe(link.d_sck_oe), .d_mosi_oe(link.d_mosi_oe), .d_miso_oe(link.d_miso_oe), .d_ss_o(link.d_ss_o),
        .d_ss_oe(link.d_ss_oe), .f_sck_o(link.f_sck_o), .f_sck_oe(link.f_sck_oe), .ss_n(link.ss_n));
    always #25 clk = ~clk;
    // wire monitor: edge timing and mosi captured at the sample edge of the current mode
    always @(link.sck) begin
        edges++;
        if (edges == 1) t0 = $time;
        t1 = $time;
        if (!link.ss_n && link.sck === (cp == ch)) wm = {wm[6:0], link.mosi};
    end
    always @(posedge clk) begin
        for (int e = 0; e < 2; e++) begin
            if (rd[e] === 1'b1 && wq[e] === 1'b0 && chk[e]) begin
                x = e ? q1.pop_front() : q0.pop_front();
                `CHK(rdat[e], x)
            end
        end
    end
    task acc(input int e, input logic w, input logic [3:0] ad, input logic [31:0] d);
        int n;
        adr[e] <= ad;
        rd[e] <= !w;
        wr[e] <= w;
        wd[e] <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wq[e] !== 1'b0 && n < 50);
        if (n == 50) n_errors++;
        junk = rdat[e];
        rd[e] <= 1'b0;
        wr[e] <= 1'b0;
        chk[e] <= 1'b0;
        @(posedge clk);
    endtask
    task dw(input logic [3:0] ad, input logic [31:0] d);
        acc(0, 1'b1, ad, d);
    endtask
    task fw(input logic [3:0] ad, input logic [31:0] d);
        acc(1, 1'b1, ad, d);
    endtask
    task cr(input int e, input logic [3:0] ad, input logic [31:0] d);
        if (e == 0) q0.push_back(d);
        else q1.push_back(d);
        chk[e] <= 1'b1;
        acc(e, 1'b0, ad, 32'h0000_0000);
    endtask
    // bounded poll until the given status bit reads one
    task poll(input int e, input logic [3:0] ad, input int bt);
        int k;
        k = 0;
        do begin
            acc(e, 1'b0, ad, 32'h0000_0000);
            k++;
        end while (junk[bt] !== 1'b1 && k < 3000);
        if (k == 3000) n_errors++;
    endtask
    task conclude;
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #4000000;
        n_errors++;
        conclude;
    end
    initial begin
        cp = 1'b0;
        ch = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cr(0, smsbs_pkg::OFS_CTRL, 32'(smsbs_pkg::CTRL_RST));
        cr(0, smsbs_pkg::OFS_STAT, 32'h0000_0000);
        cr(0, smsbs_pkg::OFS_PINS, 32'(smsbs_pkg::PINS_RST) | 32'h0000_0100);
        cr(0, 4'h1, 32'h0000_0000);
        cr(1, smsbs_pkg::F_OFS_CTRL, 32'(smsbs_pkg::F_CTRL_RST));
        cr(1, 4'hC, 32'h0000_0000);
        // far clocks a byte with select high, then a byte with select low that is raised mid-byte
        dw(smsbs_pkg::OFS_CTRL, 32'h0000_00C0);
        dw(smsbs_pkg::OFS_PINS, 32'h0000_0012);
        dw(smsbs_pkg::OFS_DATA, 32'h0000_005A);
        fw(smsbs_pkg::F_OFS_CTRL, 32'h0000_0401);
        fw(smsbs_pkg::F_OFS_DATA, 32'h0000_00C3);
        poll(1, smsbs_pkg::F_OFS_STAT, 1);
        cr(0, smsbs_pkg::OFS_STAT, 32'h0000_0000);
        fw(smsbs_pkg::F_OFS_CTRL, 32'h0000_0400);
        edges = 0;
        fw(smsbs_pkg::F_OFS_DATA, 32'h0000_00C3);
        while (edges < 6) @(posedge clk);
        fw(smsbs_pkg::F_OFS_CTRL, 32'h0000_0401);
        poll(1, smsbs_pkg::F_OFS_STAT, 1);
        cr(0, smsbs_pkg::OFS_STAT, 32'h0000_0000);
        // all four clock modes, both bit orders, first one at clock over four
        for (int i = 0; i < 8; i++) begin
            {cp, ch} = 2'(i);
            ls = i[2];
            // a target reply needs about eight clocks to come back through both synchronisers,
            // so at clock over four only a constant byte can be read back by the far end
            a = (i == 0) ? 8'hFF : 8'($random(seed));
            b = 8'($random(seed));
            rv = {<<{b}};
            fc = {(i == 0) ? 8'h02 : 8'h0C, 4'h0, ls, ch, cp, 1'b0};
            dw(smsbs_pkg::OFS_CTRL, {24'h00_0000, 2'b11, ls, 1'b0, cp, ch, 2'b00});
            dw(smsbs_pkg::OFS_DATA, {24'h00_0000, a});
            fw(smsbs_pkg::F_OFS_CTRL, {16'h0000, fc | 16'h0001});
            fw(smsbs_pkg::F_OFS_CTRL, {16'h0000, fc});
            // let the target see the select and turn its miso on before the first sample
            repeat (8) @(posedge clk);
            wm = 8'h00;
            fw(smsbs_pkg::F_OFS_DATA, {24'h00_0000, b});
            poll(0, smsbs_pkg::OFS_STAT, 7);
            `CHK(irq, 1'b1)
            cr(0, smsbs_pkg::OFS_DATA, {24'h00_0000, b});
            cr(0, smsbs_pkg::OFS_STAT, 32'h0000_0000);
            poll(1, smsbs_pkg::F_OFS_STAT, 1);
            cr(1, smsbs_pkg::F_OFS_DATA, {24'h00_0000, a});
            `CHK(wm, ls ? rv : b)
        end
        // select stays low for two more bytes; the unread one is overwritten
        fw(smsbs_pkg::F_OFS_DATA, 32'h0000_0011);
        poll(1, smsbs_pkg::F_OFS_STAT, 1);
        fw(smsbs_pkg::F_OFS_DATA, 32'h0000_0022);
        poll(1, smsbs_pkg::F_OFS_STAT, 1);
        repeat (8) @(posedge clk);
        cr(0, smsbs_pkg::OFS_STAT, 32'h0000_0080);
        cr(0, smsbs_pkg::OFS_DATA, 32'h0000_0022);
        // device as controller at every rate, with a colliding load
        fw(smsbs_pkg::F_OFS_CTRL, 32'h0000_0201);
        cp = 1'b0;
        ch = 1'b0;
        for (int r = 0; r < 8; r++) begin
            a = 8'($random(seed));
            dw(smsbs_pkg::OFS_CTRL, {24'h00_0000, 6'b010100, 2'(r)});
            dw(smsbs_pkg::OFS_PINS, 32'h0000_000D);
            dw(smsbs_pkg::OFS_STAT, 32'(r / 4));
            edges = 0;
            wm = 8'h00;
            dw(smsbs_pkg::OFS_DATA, {24'h00_0000, a});
            dw(smsbs_pkg::OFS_DATA, 32'h0000_00FF);
            poll(0, smsbs_pkg::OFS_STAT, 7);
            cr(0, smsbs_pkg::OFS_STAT, 32'h0000_00C0 | 32'(r / 4));
            cr(0, smsbs_pkg::OFS_DATA, 32'h0000_0000);
            cr(0, smsbs_pkg::OFS_STAT, 32'(r / 4));
            `CHK(edges, 16)
            `CHK(64'((t1 - t0) / 50), 64'(15 * smsbs_pkg::HALF_TAB[r]))
            `CHK(wm, a)
        end
        // far pulls select low while the device is controller with select as input
        dw(smsbs_pkg::OFS_PINS, 32'h0000_0015);
        dw(smsbs_pkg::OFS_CTRL, 32'h0000_00D0);
        fw(smsbs_pkg::F_OFS_CTRL, 32'h0000_0200);
        poll(0, smsbs_pkg::OFS_STAT, 7);
        cr(0, smsbs_pkg::OFS_CTRL, 32'h0000_00C0);
        `CHK(irq, 1'b1)
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        `CHK(irq, 1'b0)
        cr(0, smsbs_pkg::OFS_STAT, 32'h0000_0001);
        fw(smsbs_pkg::F_OFS_CTRL, 32'h0000_0201);
        conclude;
    end
endmodule
`undef CHK
`default_nettype wire
